// ==== common/hbfs_defines.svh ====
// constants for the half-bridge fault supervisor
`ifndef HBFS_DEFINES_SVH
`define HBFS_DEFINES_SVH

`define HBFS_NCH 6
`define HBFS_NSW 12
`define HBFS_AW 4
`define HBFS_DW 8

// register offsets
`define HBFS_A_GLOBAL 4'h0
`define HBFS_A_OC_HS 4'h1
`define HBFS_A_OC_LS 4'h2
`define HBFS_A_OL_HS 4'h3
`define HBFS_A_OL_LS 4'h4
`define HBFS_A_ACT_HS 4'h5
`define HBFS_A_ACT_LS 4'h6
`define HBFS_A_FWOL 4'h7

// global status bit positions
`define HBFS_B_TPW 1
`define HBFS_B_TSD 2
`define HBFS_B_NEGATED_POWER_ON_RESET_FLAG 3
`define HBFS_B_SUPPLY_OVERVOLTAGE_FLAG 4
`define HBFS_B_SUPPLY_UNDERVOLTAGE_FLAG 5
`define HBFS_B_LE 6

// synchronised pin vector layout
`define HBFS_NPIN 30
`define HBFS_P_OC_HS 0
`define HBFS_P_OC_LS 6
`define HBFS_P_UL_HS 12
`define HBFS_P_UL_LS 18
`define HBFS_P_UL_LED 24
`define HBFS_P_WARN 26
`define HBFS_P_SD 27
`define HBFS_P_UV 28
`define HBFS_P_OV 29

// timing
`define HBFS_CLK_MHZ 100
`define HBFS_OC_FILT_NS 10000
`define HBFS_DEAD_NS 1000
`define HBFS_OL_FILT_US 2000
`define HBFS_OL_LED_FILT_US 200
`define HBFS_OC_W 11
`define HBFS_OL_W 18
`define HBFS_DT_W 8

`endif

// ==== common/hbfs_pkg.sv ====
// types of the half-bridge fault supervisor
`include "hbfs_defines.svh"
package hbfs_pkg;

   typedef struct packed {
      logic [`HBFS_NPIN-1:0] s1;
      logic [`HBFS_NPIN-1:0] s2;
      logic [`HBFS_NPIN-1:0] s3;
      logic [`HBFS_NPIN-1:0] pin;
      logic [`HBFS_NCH-1:0] hs_en;
      logic [`HBFS_NCH-1:0] ls_en;
      logic [1:0] led_sel;
      logic [`HBFS_NSW-1:0] oc_flag;
      logic [`HBFS_NSW-1:0] ol_flag;
      logic le;
      logic thermal_prewarning_flag;
      logic thermal_shutdown_flag;
      logic supply_undervoltage_flag;
      logic supply_overvoltage_flag;
      logic negated_power_on_reset_flag;
      logic [`HBFS_NSW-1:0][`HBFS_OC_W-1:0] oc_cnt;
      logic [`HBFS_NSW-1:0][`HBFS_OL_W-1:0] ol_cnt;
      logic [`HBFS_NCH-1:0][`HBFS_DT_W-1:0] dt_cnt;
      logic [`HBFS_NCH-1:0] gate_hs;
      logic [`HBFS_NCH-1:0] gate_ls;
      logic stage_on;
      logic [`HBFS_DW-1:0] rdata;
   } hbfs_state_t;

endpackage

// ==== verif/hbfs_load_model.sv ====
// loads on the six outputs: current comparators follow the gates
`timescale 1ns/1ps
`default_nettype none
`include "hbfs_defines.svh"
module hbfs_load_model
   import hbfs_pkg::*;
(
   input wire logic [`HBFS_NCH-1:0] i_gate_hs,
   input wire logic [`HBFS_NCH-1:0] i_gate_ls,
   input wire logic [`HBFS_NCH-1:0] i_short,
   input wire logic [`HBFS_NCH-1:0] i_open,
   input wire logic [1:0] i_led,
   output logic [`HBFS_NCH-1:0] o_oc_hs,
   output logic [`HBFS_NCH-1:0] o_oc_ls,
   output logic [`HBFS_NCH-1:0] o_ul_hs,
   output logic [`HBFS_NCH-1:0] o_ul_ls,
   output logic [1:0] o_ul_led
);
   // no current flows unless a switch conducts, so idle outputs never look faulty
   assign o_oc_hs = i_gate_hs & i_short;
   assign o_oc_ls = i_gate_ls & i_short;
   // an led draws too little for the normal threshold but enough for the low one
   assign o_ul_hs = i_gate_hs & (i_open | {4'h0, i_led});
   assign o_ul_ls = i_gate_ls & i_open;
   assign o_ul_led = i_gate_hs[1:0] & i_open[1:0];
endmodule // hbfs_load_model
`default_nettype wire

// ==== verif/hbfs_sva_assertions.sv ====
// concurrent checks on the supervisor ports
`timescale 1ns/1ps
`default_nettype none
`include "hbfs_defines.svh"
module hbfs_sva
   import hbfs_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic [`HBFS_NCH-1:0] i_oc_hs,
   input wire logic i_temp_shutdown,
   input wire logic i_supply_uv,
   input wire logic i_supply_ov,
   input wire logic [`HBFS_NCH-1:0] o_gate_hs,
   input wire logic [`HBFS_NCH-1:0] o_gate_ls,
   input wire logic o_stage_on
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   // bridge 0 only: cycles since high side, and overcurrent while driven
   logic [7:0] dt_r;
   logic [10:0] oc_r;
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dt_r <= 8'hFF;
         oc_r <= 11'h000;
      end else begin
         dt_r <= o_gate_hs[0] ? 8'h00 : ((dt_r == 8'hFF) ? dt_r : dt_r + 8'h01);
         oc_r <= (i_oc_hs[0] && o_gate_hs[0]) ? oc_r + 11'h001 : 11'h000;
      end
   end
   cross_off_a: assert property ((o_gate_hs & o_gate_ls) == 6'h00)
      else $error("both gates of a bridge on");
   dead_time_a: assert property ($rose(o_gate_ls[0]) |-> dt_r >= 8'h64)
      else $error("low side on too soon after high side");
   oc_filter_a: assert property (oc_r < 11'h3F4)
      else $error("overcurrent switch left on past filter");
   tsd_off_a: assert property (i_temp_shutdown [*8] |-> !o_stage_on)
      else $error("stages on during shutdown temperature");
   uv_off_a: assert property (i_supply_uv [*8] |-> !o_stage_on)
      else $error("stages on during supply undervoltage");
   ov_off_a: assert property (i_supply_ov [*8] |-> !o_stage_on)
      else $error("stages on during supply overvoltage");
   gates_idle_a: assert property (!o_stage_on [*2] |-> (o_gate_hs | o_gate_ls) == 6'h00)
      else $error("gate driven while stages off");
   reset_out_a: assert property ($rose(i_reset_n) |-> !o_stage_on && (o_gate_hs | o_gate_ls) == 6'h00)
      else $error("outputs active right after reset");
   cover property ($rose(o_gate_ls[0]));
   cover property ($fell(o_stage_on));
   cover property (oc_r == 11'h3E8);
endmodule // hbfs_sva
bind hbfs_supervisor hbfs_sva i_sva (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_oc_hs(i_oc_hs),
   .i_temp_shutdown(i_temp_shutdown), .i_supply_uv(i_supply_uv), .i_supply_ov(i_supply_ov),
   .o_gate_hs(o_gate_hs), .o_gate_ls(o_gate_ls), .o_stage_on(o_stage_on));
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the half-bridge fault supervisor
`timescale 1ns/1ps
`default_nettype none
`include "hbfs_defines.svh"
module tb_top
   import hbfs_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, warn = 1'b0, hot = 1'b0, uv = 1'b0, ov = 1'b0;
   logic stage_on;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic [1:0] ul_led;
   logic [1:0] led_m = 2'b00;
   logic [5:0] g_hs, g_ls, oc_hs, oc_ls, ul_hs, ul_ls, fw_hs = 6'h00, short_m = 6'h00, open_m = 6'h00;
   int errors = 0;
   int checked = 0;
   hbfs_supervisor #(.OL_FILT_US(1), .OL_LED_FILT_US(1)) i_dut (
      .i_core_clk(clk), .i_reset_n(rst_n), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_oc_hs(oc_hs), .i_oc_ls(oc_ls), .i_undercur_hs(ul_hs), .i_undercur_ls(ul_ls),
      .i_undercur_led(ul_led), .i_temp_warn(warn), .i_temp_shutdown(hot), .i_supply_uv(uv), .i_supply_ov(ov),
      .i_freewheel_hs(fw_hs), .i_freewheel_ls(6'h00), .o_gate_hs(g_hs), .o_gate_ls(g_ls), .o_stage_on(stage_on));
   hbfs_load_model i_load (.i_gate_hs(g_hs), .i_gate_ls(g_ls), .i_short(short_m), .i_open(open_m), .i_led(led_m),
      .o_oc_hs(oc_hs), .o_oc_ls(oc_ls), .o_ul_hs(ul_hs), .o_ul_ls(ul_ls), .o_ul_led(ul_led));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic gate_at(input int n, input logic hs, input logic [5:0] exp);
      repeat (n) @(posedge clk);
      #1 chk({2'h0, hs ? g_hs : g_ls}, {2'h0, exp});
   endtask
   task automatic t_regs();
      reg_rd(4'h0, 8'h00);
      reg_rd(4'hF, 8'h00);
      reg_wr(4'h0, 8'h08);
      reg_rd(4'h0, 8'h08);
      reg_wr(4'h5, 8'h01);
      reg_rd(4'h5, 8'h01);
   endtask
   task automatic t_dead();
      reg_wr(4'h6, 8'h01);
      gate_at(2, 1'b1, 6'h00);
      reg_wr(4'h5, 8'h00);
      gate_at(50, 1'b0, 6'h00);
      gate_at(60, 1'b0, 6'h01);
      reg_wr(4'h6, 8'h00);
      reg_wr(4'h5, 8'h01);
      gate_at(50, 1'b1, 6'h00);
      gate_at(60, 1'b1, 6'h01);
   endtask
   task automatic t_temp();
      @(posedge clk) warn <= 1'b1;
      gate_at(10, 1'b1, 6'h01);
      reg_rd(4'h0, 8'h0A);
      reg_wr(4'h0, 8'h02);
      reg_rd(4'h0, 8'h0A);
      @(posedge clk) warn <= 1'b0;
      gate_at(10, 1'b1, 6'h01);
      reg_wr(4'h0, 8'h02);
      reg_rd(4'h0, 8'h08);
      @(posedge clk) hot <= 1'b1;
      gate_at(10, 1'b1, 6'h00);
      reg_wr(4'h0, 8'h04);
      reg_rd(4'h0, 8'h0C);
      @(posedge clk) hot <= 1'b0;
      gate_at(120, 1'b1, 6'h00);
      reg_rd(4'h5, 8'h01);
      reg_wr(4'h0, 8'h04);
      gate_at(120, 1'b1, 6'h01);
      reg_rd(4'h0, 8'h08);
   endtask
   task automatic t_supply();
      logic [7:0] fl;
      for (int k = 0; k < 2; k++) begin
         fl = k[0] ? 8'h18 : 8'h28;
         @(posedge clk) {ov, uv} <= k[0] ? 2'b10 : 2'b01;
         gate_at(10, 1'b1, 6'h00);
         chk({7'h00, stage_on}, 8'h00);
         reg_rd(4'h0, fl);
         reg_rd(4'h5, 8'h01);
         @(posedge clk) {ov, uv} <= 2'b00;
         gate_at(120, 1'b1, 6'h01);
         chk({7'h00, stage_on}, 8'h01);
         reg_rd(4'h0, fl);
         reg_wr(4'h0, fl & 8'h30);
         reg_rd(4'h0, 8'h08);
      end
   endtask
   task automatic t_oc();
      @(posedge clk) short_m <= 6'h01;
      gate_at(1100, 1'b1, 6'h00);
      reg_rd(4'h1, 8'h01);
      reg_rd(4'h0, 8'h48);
      reg_rd(4'h5, 8'h01);
      @(posedge clk) short_m <= 6'h00;
      gate_at(20, 1'b1, 6'h00);
      reg_wr(4'h1, 8'h01);
      reg_wr(4'h0, 8'h40);
      gate_at(120, 1'b1, 6'h01);
      reg_rd(4'h0, 8'h08);
   endtask
   task automatic t_ol();
      @(posedge clk) open_m <= 6'h01;
      gate_at(150, 1'b1, 6'h01);
      reg_rd(4'h3, 8'h01);
      reg_rd(4'h0, 8'h48);
      @(posedge clk) fw_hs <= 6'h01;
      reg_wr(4'h3, 8'h01);
      reg_wr(4'h0, 8'h40);
      gate_at(150, 1'b1, 6'h01);
      reg_rd(4'h3, 8'h00);
      @(posedge clk) open_m <= 6'h00;
      fw_hs <= 6'h00;
      led_m <= 2'b10;
      reg_wr(4'h7, 8'h02);
      reg_wr(4'h5, 8'h02);
      gate_at(150, 1'b1, 6'h02);
      reg_rd(4'h3, 8'h00);
      reg_wr(4'h7, 8'h00);
      gate_at(150, 1'b1, 6'h02);
      reg_rd(4'h3, 8'h02);
   endtask
   task automatic give_verdict();
      if (errors == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_dead();
      t_temp();
      t_supply();
      t_oc();
      t_ol();
      give_verdict();
   end
   initial begin
      #200_000;
      errors++;
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire

// ==== verilog/hbfs_supervisor.sv ====
// fault supervision and gate control for six half-bridges
//
// Contract
// (R01) overcurrent: enables stay, bridge off, flags set
// (R02) never both transistors of a bridge on
// (R03) dead time on every side change
// (R04) warning temperature sets prewarning flag
// (R05) prewarning latched; clears only below warning
// (R06) prewarning alone leaves outputs on
// (R07) shutdown temperature latches all outputs off
// (R08) outputs stay off until shutdown flag cleared
// (R09) controller clears shutdown flag to resume
// (R10) supply undervoltage: outputs off, flag latched
// (R11) undervoltage recovery reenables stages automatically
// (R12) controller clears undervoltage flag to recheck
// (R13) supply overvoltage: outputs off, flag latched
// (R14) overvoltage recovery reenables; flag stays latched
// (R15) logic reset initialises, outputs off
// (R16) power-on reset reported as flag zero
// (R17) open load after filter time latches flag
// (R18) open load also sets global load error
// (R19) open load leaves bridge active
// (R20) controller clears open load to recheck
// (R21) first two high sides: led threshold option
// (R22) free-wheeling stages blank open load
// (R23) overcurrent off after filter, while flag set
// (R24) flags cleared only by controller access
// (R25) persisting fault sets flag again
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module hbfs_supervisor
   import hbfs_pkg::*;
#(
   parameter int unsigned OL_FILT_US = `HBFS_OL_FILT_US,
   parameter int unsigned OL_LED_FILT_US = `HBFS_OL_LED_FILT_US
) (
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   input wire logic [`HBFS_AW-1:0] i_addr,
   input wire logic [`HBFS_DW-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [`HBFS_DW-1:0] o_rdata,
   input wire logic [`HBFS_NCH-1:0] i_oc_hs,
   input wire logic [`HBFS_NCH-1:0] i_oc_ls,
   input wire logic [`HBFS_NCH-1:0] i_undercur_hs,
   input wire logic [`HBFS_NCH-1:0] i_undercur_ls,
   input wire logic [1:0] i_undercur_led,
   input wire logic i_temp_warn,
   input wire logic i_temp_shutdown,
   input wire logic i_supply_uv,
   input wire logic i_supply_ov,
   input wire logic [`HBFS_NCH-1:0] i_freewheel_hs,
   input wire logic [`HBFS_NCH-1:0] i_freewheel_ls,
   output logic [`HBFS_NCH-1:0] o_gate_hs,
   output logic [`HBFS_NCH-1:0] o_gate_ls,
   output logic o_stage_on
);

   localparam int unsigned OC_CYC = (`HBFS_OC_FILT_NS * `HBFS_CLK_MHZ + 999) / 1000;
   localparam int unsigned DT_CYC = (`HBFS_DEAD_NS * `HBFS_CLK_MHZ + 999) / 1000;
   localparam int unsigned OL_CYC = OL_FILT_US * `HBFS_CLK_MHZ;
   localparam int unsigned OL_LED_CYC = OL_LED_FILT_US * `HBFS_CLK_MHZ;
   localparam logic [`HBFS_OC_W-1:0] OC_LIM = `HBFS_OC_W'(OC_CYC - 1);
   localparam logic [`HBFS_DT_W-1:0] DT_LOAD = `HBFS_DT_W'(DT_CYC);
   localparam logic [`HBFS_OL_W-1:0] OL_LIM = `HBFS_OL_W'(OL_CYC - 1);
   localparam logic [`HBFS_OL_W-1:0] OL_LED_LIM = `HBFS_OL_W'(OL_LED_CYC - 1);

   hbfs_state_t r;
   hbfs_state_t n;

   logic [`HBFS_NPIN-1:0] pins;
   logic [`HBFS_NSW-1:0] oc_live;
   logic [`HBFS_NSW-1:0] ul_live;
   logic [`HBFS_NSW-1:0] gate_on;
   logic [`HBFS_NSW-1:0] fw;
   logic [`HBFS_NSW-1:0] oc_clr;
   logic [`HBFS_NSW-1:0] ol_clr;
   logic [`HBFS_DW-1:0] g_clr;
   logic stage_ok;
   logic want_hs;
   logic want_ls;

   // filter limit for a switch; the first two high sides may use the led setting
   function automatic logic [`HBFS_OL_W-1:0] ol_limit(input int k, input logic [1:0] sel);
      ol_limit = (k < 2 && sel[k[0]]) ? OL_LED_LIM : OL_LIM; // R21
   endfunction

   function automatic logic [`HBFS_DW-1:0] pad6(input logic [`HBFS_NCH-1:0] v);
      pad6 = {2'h0, v};
   endfunction

   assign pins[`HBFS_P_OC_HS+:`HBFS_NCH] = i_oc_hs;
   assign pins[`HBFS_P_OC_LS+:`HBFS_NCH] = i_oc_ls;
   assign pins[`HBFS_P_UL_HS+:`HBFS_NCH] = i_undercur_hs;
   assign pins[`HBFS_P_UL_LS+:`HBFS_NCH] = i_undercur_ls;
   assign pins[`HBFS_P_UL_LED+:2] = i_undercur_led;
   assign pins[`HBFS_P_WARN] = i_temp_warn;
   assign pins[`HBFS_P_SD] = i_temp_shutdown;
   assign pins[`HBFS_P_UV] = i_supply_uv;
   assign pins[`HBFS_P_OV] = i_supply_ov;

   always_comb begin
      n = r;

      // three-stage sync; a change is taken once stages two and three agree
      n.s1 = pins;
      n.s2 = r.s1;
      n.s3 = r.s2;
      for (int i = 0; i < `HBFS_NPIN; i++) begin
         if (r.s2[i] == r.s3[i]) begin
            n.pin[i] = r.s3[i];
         end
      end

      // high sides in the low bits, low sides above them
      oc_live = r.pin[`HBFS_P_OC_HS+:`HBFS_NSW];
      ul_live[`HBFS_NCH-1:0] = r.pin[`HBFS_P_UL_HS+:`HBFS_NCH];
      ul_live[`HBFS_NSW-1:`HBFS_NCH] = r.pin[`HBFS_P_UL_LS+:`HBFS_NCH];
      // the led comparators stand in for the normal ones when selected
      if (r.led_sel[0]) begin
         ul_live[0] = r.pin[`HBFS_P_UL_LED]; // R21
      end
      if (r.led_sel[1]) begin
         ul_live[1] = r.pin[`HBFS_P_UL_LED+1]; // R21
      end
      gate_on = {r.gate_ls, r.gate_hs};
      fw = {i_freewheel_ls, i_freewheel_hs};

      // register writes; flag clears go first so a same-cycle detection wins
      oc_clr = '0;
      ol_clr = '0;
      g_clr = '0;
      if (i_wr) begin
         case (i_addr)
            `HBFS_A_GLOBAL: begin
               g_clr = i_wdata; // R24
            end
            `HBFS_A_OC_HS: begin
               oc_clr[`HBFS_NCH-1:0] = i_wdata[`HBFS_NCH-1:0]; // R24
            end
            `HBFS_A_OC_LS: begin
               oc_clr[`HBFS_NSW-1:`HBFS_NCH] = i_wdata[`HBFS_NCH-1:0]; // R24
            end
            `HBFS_A_OL_HS: begin
               ol_clr[`HBFS_NCH-1:0] = i_wdata[`HBFS_NCH-1:0]; // R24
            end
            `HBFS_A_OL_LS: begin
               ol_clr[`HBFS_NSW-1:`HBFS_NCH] = i_wdata[`HBFS_NCH-1:0]; // R24
            end
            `HBFS_A_ACT_HS: begin
               n.hs_en = i_wdata[`HBFS_NCH-1:0];
            end
            `HBFS_A_ACT_LS: begin
               n.ls_en = i_wdata[`HBFS_NCH-1:0];
            end
            `HBFS_A_FWOL: begin
               n.led_sel = i_wdata[1:0]; // R21
            end
            default: begin
            end
         endcase
      end

      n.oc_flag = r.oc_flag & ~oc_clr;
      n.ol_flag = r.ol_flag & ~ol_clr;
      if (g_clr[`HBFS_B_LE]) begin
         n.le = 1'b0;
      end
      if (g_clr[`HBFS_B_TPW]) begin
         n.thermal_prewarning_flag = 1'b0;
      end
      if (g_clr[`HBFS_B_TSD]) begin
         n.thermal_shutdown_flag = 1'b0; // R08
      end
      if (g_clr[`HBFS_B_SUPPLY_UNDERVOLTAGE_FLAG]) begin
         n.supply_undervoltage_flag = 1'b0;
      end
      if (g_clr[`HBFS_B_SUPPLY_OVERVOLTAGE_FLAG]) begin
         n.supply_overvoltage_flag = 1'b0;
      end
      // acknowledging the reset report turns the negated flag to one
      if (g_clr[`HBFS_B_NEGATED_POWER_ON_RESET_FLAG]) begin
         n.negated_power_on_reset_flag = 1'b1; // R16
      end

      // overcurrent filters: only a conducting switch can see overcurrent
      for (int k = 0; k < `HBFS_NSW; k++) begin
         if (gate_on[k] && oc_live[k]) begin
            if (r.oc_cnt[k] >= OC_LIM) begin
               n.oc_flag[k] = 1'b1; // R01 R23 R25
               n.le = 1'b1; // R01
            end else begin
               n.oc_cnt[k] = r.oc_cnt[k] + `HBFS_OC_W'(1); // R23
            end
         end else begin
            n.oc_cnt[k] = '0;
         end
      end

      // open-load filters; free-wheeling stages never accumulate open-load time
      for (int k = 0; k < `HBFS_NSW; k++) begin
         if (gate_on[k] && ul_live[k] && !fw[k]) begin // R22
            if (r.ol_cnt[k] >= ol_limit(k, r.led_sel)) begin
               n.ol_flag[k] = 1'b1; // R17 R25
               n.le = 1'b1; // R18
            end else begin
               n.ol_cnt[k] = r.ol_cnt[k] + `HBFS_OL_W'(1); // R17
            end
         end else begin
            n.ol_cnt[k] = '0;
         end
      end

      // global conditions
      if (r.pin[`HBFS_P_WARN]) begin
         n.thermal_prewarning_flag = 1'b1; // R04 R05
      end
      if (r.pin[`HBFS_P_SD]) begin
         n.thermal_shutdown_flag = 1'b1; // R07 R25
      end
      if (r.pin[`HBFS_P_UV]) begin
         n.supply_undervoltage_flag = 1'b1; // R10
      end
      if (r.pin[`HBFS_P_OV]) begin
         n.supply_overvoltage_flag = 1'b1; // R13
      end

      // live supply levels gate the stages, the flags do not: recovery is automatic
      stage_ok = !n.thermal_shutdown_flag && !r.pin[`HBFS_P_UV] && !r.pin[`HBFS_P_OV]; // R06 R08 R10 R11 R13 R14
      n.stage_on = stage_ok;

      // gate sequencing; open load never enters here, so it leaves outputs alone
      want_hs = 1'b0;
      want_ls = 1'b0;
      for (int c = 0; c < `HBFS_NCH; c++) begin
         // both enables set means neither side conducts
         want_hs = r.hs_en[c] && !r.ls_en[c]
            && !n.oc_flag[c] && stage_ok; // R02 R19
         want_ls = r.ls_en[c] && !r.hs_en[c]
            && !n.oc_flag[c+`HBFS_NCH] && stage_ok; // R02 R19
         if ((r.gate_hs[c] && !want_hs) || (r.gate_ls[c] && !want_ls)) begin
            n.gate_hs[c] = 1'b0; // R01 R07 R10 R13
            n.gate_ls[c] = 1'b0;
            n.dt_cnt[c] = DT_LOAD; // R03
         end else if (!r.gate_hs[c] && !r.gate_ls[c]) begin
            // the dead time runs down even while nothing is wanted
            if (r.dt_cnt[c] != '0) begin
               n.dt_cnt[c] = r.dt_cnt[c] - `HBFS_DT_W'(1); // R03
            end else begin
               n.gate_hs[c] = want_hs; // R02
               n.gate_ls[c] = want_ls;
            end
         end
      end

      // read data stand for the single cycle after the strobe
      n.rdata = '0;
      if (i_rd) begin
         case (i_addr)
            `HBFS_A_GLOBAL: begin
               n.rdata[`HBFS_B_LE] = r.le;
               n.rdata[`HBFS_B_TPW] = r.thermal_prewarning_flag;
               n.rdata[`HBFS_B_TSD] = r.thermal_shutdown_flag;
               n.rdata[`HBFS_B_SUPPLY_UNDERVOLTAGE_FLAG] = r.supply_undervoltage_flag;
               n.rdata[`HBFS_B_SUPPLY_OVERVOLTAGE_FLAG] = r.supply_overvoltage_flag;
               n.rdata[`HBFS_B_NEGATED_POWER_ON_RESET_FLAG] = r.negated_power_on_reset_flag; // R16
            end
            `HBFS_A_OC_HS: begin
               n.rdata = pad6(r.oc_flag[`HBFS_NCH-1:0]);
            end
            `HBFS_A_OC_LS: begin
               n.rdata = pad6(r.oc_flag[`HBFS_NSW-1:`HBFS_NCH]);
            end
            `HBFS_A_OL_HS: begin
               n.rdata = pad6(r.ol_flag[`HBFS_NCH-1:0]);
            end
            `HBFS_A_OL_LS: begin
               n.rdata = pad6(r.ol_flag[`HBFS_NSW-1:`HBFS_NCH]);
            end
            `HBFS_A_ACT_HS: begin
               n.rdata = pad6(r.hs_en); // R01 R07
            end
            `HBFS_A_ACT_LS: begin
               n.rdata = pad6(r.ls_en);
            end
            `HBFS_A_FWOL: begin
               n.rdata = {6'h00, r.led_sel};
            end
            default: begin
               n.rdata = '0;
            end
         endcase
      end
   end

   // reset clears all logic and leaves every stage off
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         r <= '0; // R15 R16
      end else if (i_ce) begin
         r <= n;
      end
   end

   assign o_rdata = r.rdata;
   assign o_gate_hs = r.gate_hs;
   assign o_gate_ls = r.gate_ls;
   assign o_stage_on = r.stage_on;

endmodule // hbfs_supervisor

`default_nettype wire
